// [hdl/disp_drv.sv]
// Serial-in display driver: shift register, output latch, blanking, cascade.
// Assumes host pins are asynchronous to core_clk and slow (host clock far
// below core_clk), so two-flop synchronisers and edge detection suffice.
//
// How it works
// R1: Shift clock edges are ignored unless the load envelope is high.
// R2: Each rising shift clock edge inside the envelope shifts in one data bit.
// R3: The falling envelope copies the shift register into the output latch.
// R4: Outputs keep the old latched data while shifting goes on.
// R5: The cascade output changes on the falling shift clock edge.
// R6: Blanking high forces every display output off at any time.
// R7: The first bit shifted after the envelope rises lands on output 1.
// R8: A latched one turns its output on, a zero leaves it off.
// R9: The host clears the driver by shifting 20 zeroes then closing the envelope.
// R10: The host should run that clearing sequence after power-up.
// R11: Envelope and blanking act independently of each other.
// R12: The register has 20 stages and the cascade output carries the last one.
`timescale 1ns/10ps
`default_nettype none

// ========================================
// FIFO carrying sampled data bits toward the shift register
module disp_fifo #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 32
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    wr_next;
    logic [AW-1:0]    rd_reg;
    logic [AW-1:0]    rd_next;
    logic [AW:0]      cnt_reg;
    logic [AW:0]      cnt_next;
    logic             push;
    logic             pop;

    // Pointer and fill count next values
    always_comb begin
        push     = in_valid && in_ready;
        pop      = out_valid && out_ready;
        wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
        rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
        cnt_next = cnt_reg;
        if (push && !pop) begin
            cnt_next = (AW+1)'(cnt_reg + 1'b1);
        end else if (pop && !push) begin
            cnt_next = (AW+1)'(cnt_reg - 1'b1);
        end
    end

    // Register pointers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage write
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    // Honest full and empty
    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rd_reg];
endmodule : disp_fifo

// ========================================
// Top level driver core
module disp_drv #(
    parameter int unsigned STAGES = disp_drv_pkg::STAGES
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // Host serial pins
    input  wire logic              data_in,
    input  wire logic              shift_clk,
    input  wire logic              load_env,
    input  wire logic              blank,
    // Cascade and display
    output logic                   data_out,
    output logic      [STAGES-1:0] disp_out,
    // Back-pressure: low when a data bit could be lost
    output logic                   accept_ready
);
    // Synchroniser chains: stage 0 read only by stage 1
    logic [1:0] sd_reg;
    logic [1:0] sc_reg;
    logic [1:0] se_reg;
    logic [1:0] sb_reg;
    logic       sc_d_reg;
    logic       se_d_reg;
    logic [STAGES-1:0] shift_reg;
    logic [STAGES-1:0] shift_next;
    logic [STAGES-1:0] latch_reg;
    logic [STAGES-1:0] latch_next;
    logic              dout_reg;
    logic              dout_next;
    logic [STAGES-1:0] disp_reg;
    logic [STAGES-1:0] disp_next;
    logic              rdy_reg;
    logic              pend_reg;
    logic              pend_next;
    logic              rise;
    logic              fall;
    logic              env_fall;
    logic              f_valid;
    logic              f_data;
    logic              f_ready;
    logic              f_out_valid;
    logic              f_out_data;
    logic              f_pop;

    // Pin synchronisers and edge history
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sd_reg   <= 2'h0;
            sc_reg   <= 2'h0;
            se_reg   <= 2'h0;
            sb_reg   <= 2'h0;
            sc_d_reg <= 1'b0;
            se_d_reg <= 1'b0;
        end else begin
            sd_reg   <= {sd_reg[0], data_in};
            sc_reg   <= {sc_reg[0], shift_clk};
            se_reg   <= {se_reg[0], load_env};
            sb_reg   <= {sb_reg[0], blank};
            sc_d_reg <= sc_reg[1];
            se_d_reg <= se_reg[1];
        end
    end

    // Edge detection on synchronised pins
    always_comb begin
        rise     = sc_reg[1] && !sc_d_reg && se_reg[1]; // R1 R11
        fall     = !sc_reg[1] && sc_d_reg && se_reg[1]; // R1
        env_fall = !se_reg[1] && se_d_reg;
        f_valid  = rise; // R2
        f_data   = sd_reg[1];
    end

    // Sampled bits queue up and drain one per cycle; at close the latch waits for the queue to empty
    disp_fifo #(
        .WIDTH (1),
        .DEPTH (disp_drv_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (f_valid),
        .in_ready  (f_ready),
        .in_data   (f_data),
        .out_valid (f_out_valid),
        .out_ready (f_pop),
        .out_data  (f_out_data)
    );

    // Shift, latch, cascade and display next values
    always_comb begin
        f_pop      = f_out_valid;
        shift_next = shift_reg;
        latch_next = latch_reg;
        dout_next  = dout_reg;
        pend_next  = pend_reg;
        // New bits enter at the top and walk down, so bit 0 (output 1)
        // ends up holding the first bit of a 20-bit frame
        if (f_pop) begin
            shift_next = {f_out_data, shift_reg[STAGES-1:1]}; // R2 R7 R12
        end
        // Latch only once all queued bits have been shifted; a close that
        // meets a bit still in flight is remembered, not lost
        if ((env_fall || pend_reg) && !f_out_valid) begin
            latch_next = shift_reg; // R3 R11
            pend_next  = 1'b0;
        end else if (env_fall) begin
            pend_next  = 1'b1;
        end
        // Bit 0 is the final stage: it leaves first toward the next device
        if (fall) begin
            dout_next = shift_reg[0]; // R5 R12
        end
        // Blanking gates the outputs only, never the latch
        disp_next = sb_reg[1] ? '0 : latch_reg; // R4 R6 R8 R11
    end

    // Core state registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            shift_reg <= disp_drv_pkg::SHIFT_RST;
            latch_reg <= disp_drv_pkg::LATCH_RST;
            dout_reg  <= 1'b0;
            disp_reg  <= '0;
            rdy_reg   <= 1'b0;
            pend_reg  <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            latch_reg <= latch_next;
            dout_reg  <= dout_next;
            disp_reg  <= disp_next;
            rdy_reg   <= f_ready;
            pend_reg  <= pend_next;
        end
    end

    assign data_out     = dout_reg;
    assign disp_out     = disp_reg;
    assign accept_ready = rdy_reg;
endmodule : disp_drv

`default_nettype wire

// [hdl/disp_drv_pkg.sv]
// Constants for the serial display driver core.
// Assumes a single core_clk domain; host pins arrive asynchronously.
package disp_drv_pkg;
    // ========================================
    // Structure
    localparam int unsigned STAGES      = 20;
    localparam int unsigned FIFO_DEPTH  = 32;
    localparam int unsigned SYNC_STAGES = 2;
    // ========================================
    // Reset values
    localparam logic [19:0] SHIFT_RST   = 20'h00000;
    localparam logic [19:0] LATCH_RST   = 20'h00000;
    // ========================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 100;
endpackage : disp_drv_pkg

// [tb/disp_drv_monitor.sv]
// Port checker for the display driver core.
// Bound to disp_drv from tb_top; pins change just after core_clk edges.
`timescale 1ns/10ps
`default_nettype none
// ====
// Checker
module disp_drv_monitor #(parameter int unsigned STAGES = 20) (
    // Watched ports
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              shift_clk,
    input wire logic              load_env,
    input wire logic              blank,
    input wire logic              data_out,
    input wire logic [STAGES-1:0] disp_out,
    input wire logic              accept_ready
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    AST_BLANK_ON: assert property
        (blank[*4] |-> disp_out == '0) else $error("lit while blanked");
    AST_BLANK_FAST: assert property
        ($rose(blank) |-> ##[0:4] disp_out == '0) else $error("slow blank");
    AST_HOLD_SHIFT: assert property
        ((load_env && !blank)[*8] |-> $stable(disp_out))
        else $error("display moved while shifting");
    AST_IDLE_DISP: assert property
        ((!load_env && !blank)[*8] |-> $stable(disp_out))
        else $error("display moved while idle");
    AST_IDLE_CASCADE: assert property
        ((!load_env)[*8] |-> $stable(data_out)) else $error("clock not ignored");
    AST_CASCADE_FALL: assert property
        ($changed(data_out) |-> !$past(shift_clk, 2))
        else $error("cascade moved after a rise");
    AST_CASCADE_HIGH: assert property
        (shift_clk[*5] |-> $stable(data_out)) else $error("cascade moved high");
    AST_READY_IDLE: assert property
        ((!load_env)[*8] |-> accept_ready) else $error("not ready when idle");
    // Main scenarios
    CV_LATCH: cover property ($fell(load_env));
    CV_BLANK_SHIFT: cover property (blank && load_env);
    CV_CASCADE: cover property ($changed(data_out));
endmodule : disp_drv_monitor
`default_nettype wire

// [tb/host_model.sv]
// Host processor model driving the serial pins in frames.
// Pins change 1 ns after core_clk edges; core_clk is 10 MHz.
`timescale 1ns/10ps
`default_nettype none
// ====
// Host
module host_model (
    // Clock and host pins
    input  wire logic core_clk,
    output var logic  data_in = 1'b0,
    output var logic  shift_clk = 1'b0,
    output var logic  load_env = 1'b0
);
    // Wait n edges, then step just off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    // Twenty bits, bit 0 first; env low gives stray pulses
    task automatic frame(input logic [19:0] bits, input logic env);
        load_env = env;
        tick(4);
        for (int k = 0; k < 20; k++) begin
            data_in = bits[k];
            tick(3);
            shift_clk = 1'b1;
            tick(5);
            shift_clk = 1'b0;
            tick(5);
        end
        data_in = ~data_in; // Hold time over: no stale level
        tick(4);
        load_env = 1'b0;
        tick(8);
    endtask : frame
endmodule : host_model
`default_nettype wire

// [tb/tb_top.sv]
// Top bench: driver core, host model, bound checker.
// One 10 MHz core_clk; expected display values queued in order.
`timescale 1ns/10ps
`default_nettype none
// ====
// Bench
module tb_top;
    logic core_clk = 1'b0, rst = 1'b1, blank = 1'b0;
    logic data_in, shift_clk, load_env, data_out, accept_ready;
    logic [19:0] disp_out, prev = '0, seen = '0, b, q[$];
    int fails = 0, n_checks = 0;
    always #50 core_clk = ~core_clk;
    disp_drv #(.STAGES(20)) u_dut (.core_clk(core_clk), .rst(rst),
        .data_in(data_in), .shift_clk(shift_clk), .load_env(load_env),
        .blank(blank), .data_out(data_out), .disp_out(disp_out),
        .accept_ready(accept_ready));
    host_model u_host (.core_clk(core_clk), .data_in(data_in),
        .shift_clk(shift_clk), .load_env(load_env));
    // Compare and count
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Queue a display value only when it differs from the last
    task automatic note(input logic [19:0] v);
        if (v !== prev)
            q.push_back(v);
        prev = v;
    endtask : note
    // Each display change takes the oldest note
    always @(negedge core_clk) if (!rst && disp_out !== seen) begin
        seen = disp_out;
        chk(disp_out, (q.size() > 0) ? q.pop_front() : ~disp_out);
    end
    // Verdict
    task automatic summarize();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    // Main sequence
    initial begin
        b = 20'($urandom(19379));
        repeat (12) @(posedge core_clk);
        #1 rst = 1'b0;
        u_host.frame('0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            b = 20'($urandom);
            // Display changes before the frame task returns: note first
            if (i != 2)
                note(b);
            fork
                u_host.frame(b, 1'b1);
                if (i == 2) begin
                    u_host.tick(90);
                    blank = 1'b1;
                    note('0);
                end
            join
            u_host.tick(6);
            blank = 1'b0;
            if (i == 2)
                note(b);
            chk(20'(data_out), 20'(b[0]));
            u_host.frame(~b, 1'b0);
            chk(20'(data_out), 20'(b[0]));
        end
        // Bit queue inside the core drains every cycle, so never refuses
        b = 20'($urandom);
        note(b);
        fork
            u_host.frame(b, 1'b1);
            for (int k = 0; k < 32; k++) begin
                chk(20'(accept_ready), 20'h00001);
                u_host.tick(8);
            end
        join
        chk(20'(accept_ready), 20'h00001);
        chk(20'(data_out), 20'(b[0]));
        for (int k = 0; k < 50 && q.size() > 0; k++)
            u_host.tick(1);
        if (q.size() > 0)
            fails++;
        summarize();
    end
endmodule : tb_top
bind disp_drv disp_drv_monitor #(.STAGES(STAGES)) u_mon (
    .core_clk(core_clk), .rst(rst), .shift_clk(shift_clk),
    .load_env(load_env), .blank(blank), .data_out(data_out),
    .disp_out(disp_out), .accept_ready(accept_ready));
`default_nettype wire
